// ---- design/agp_cfg_pkg.sv ----
// constants for the bridge function configuration bank
// assumes one system clock and dword configuration accesses with byte enables
package agp_cfg_pkg;

    // ------------------------------------------------------------------
    // access port widths
    // ------------------------------------------------------------------
    localparam int CFG_AW = 8;
    localparam int CFG_DW = 32;
    localparam int CFG_BW = 4;

    // ------------------------------------------------------------------
    // byte offsets in configuration space
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_VENDOR_ID = 8'h00;
    localparam logic [7:0] OFF_DEVICE_ID = 8'h02;
    localparam logic [7:0] OFF_BRIDGE_CMD = 8'h04;
    localparam logic [7:0] OFF_BRIDGE_STS = 8'h06;
    localparam logic [7:0] OFF_REVISION = 8'h08;
    localparam logic [7:0] OFF_SUB_CLASS = 8'h0a;
    localparam logic [7:0] OFF_BASE_CLASS = 8'h0b;
    localparam logic [7:0] OFF_MASTER_LAT = 8'h0d;
    localparam logic [7:0] OFF_HEADER_TYPE = 8'h0e;
    localparam logic [7:0] OFF_PRIMARY_BUS = 8'h18;
    localparam logic [7:0] OFF_SECONDARY_BUS = 8'h19;
    localparam logic [7:0] OFF_SUBORD_BUS = 8'h1a;
    localparam logic [7:0] OFF_SECONDARY_LAT = 8'h1b;
    localparam logic [7:0] OFF_IO_BASE = 8'h1c;
    localparam logic [7:0] OFF_IO_LIMIT = 8'h1d;
    localparam logic [7:0] OFF_SECONDARY_STS = 8'h1e;
    localparam logic [7:0] OFF_MEM_BASE = 8'h20;
    localparam logic [7:0] OFF_MEM_LIMIT = 8'h22;
    localparam logic [7:0] OFF_PREF_BASE = 8'h24;
    localparam logic [7:0] OFF_PREF_LIMIT = 8'h26;
    localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h3e;
    localparam logic [7:0] OFF_ERROR_CMD = 8'h40;

    // ------------------------------------------------------------------
    // values after reset and fixed read values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_BRIDGE_CMD = 16'h0000;
    localparam logic [15:0] RST_BRIDGE_STS = 16'h0020;
    localparam logic [7:0] RST_SUB_CLASS = 8'h04;
    localparam logic [7:0] RST_BASE_CLASS = 8'h06;
    localparam logic [7:0] RST_HEADER_TYPE = 8'h01;
    localparam logic [7:0] RST_PRIMARY_BUS = 8'h00;
    localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
    localparam logic [7:0] RST_IO_BASE = 8'hf0;
    localparam logic [7:0] RST_IO_LIMIT = 8'h00;
    localparam logic [15:0] RST_SECONDARY_STS = 16'h02a0;
    localparam logic [15:0] RST_WIN_BASE = 16'hfff0;
    localparam logic [15:0] RST_WIN_LIMIT = 16'h0000;
    localparam logic [31:0] RD_HIDDEN = 32'hffff_ffff;
    localparam logic [31:0] RD_RESERVED = 32'h0000_0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CMD_IO_EN_BIT = 0;
    localparam int CMD_MEM_EN_BIT = 1;
    localparam int CMD_BME_BIT = 2;
    localparam int CMD_SERRE_BIT = 8;
    localparam int CMD_FAST_BTB_BIT = 9;
    localparam logic [15:0] CMD_WR_MASK = 16'h0107;
    localparam int CTRL_PARITY_SERR_BIT = 2;
    localparam int ERRCMD_TA_SERR_BIT = 0;
    // sticky status bits: 0 received target abort, 1 signaled system
    // error, 2 detected parity error
    localparam int STS_NUM = 3;
    localparam int STS_TA = 0;
    localparam int STS_SERR = 1;
    localparam int STS_PERR = 2;
    localparam int STS_POS_TA = 12;
    localparam int STS_POS_SERR = 14;
    localparam int STS_POS_PERR = 15;

endpackage : agp_cfg_pkg

// ---- design/hub_serr_msg.sv ----
// hub interface system-error message launcher
// assumes the hub side holds ready on the same clock
`timescale 1ns/1ps
module hub_serr_msg (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic enable,
    input wire logic req,
    input wire logic ready,
    output logic valid
);
    import agp_cfg_pkg::*;

    logic fire;

    // requests during a pending message merge into it: one message
    // already tells the hub that a system error occurred
    assign fire = req && enable;

    // ------------------------------------------------------------------
    // message request held until the hub takes it
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            valid <= 1'b0;
        end else if (ce) begin
            if (valid && ready) begin
                valid <= fire;
            end else if (fire) begin
                valid <= 1'b1;
            end
        end
    end

    property p_msg_hold;
        @(posedge mclk) disable iff (!rst_b)
        valid && !(ready && ce) |=> valid;
    endproperty
    a_msg_hold: assert property (p_msg_hold)
        else $error("system error message dropped before hub took it");

endmodule : hub_serr_msg

// ---- design/agp_bridge_config_space.sv ----
// configuration register bank of the bridge function
// assumes single-cycle dword configuration requests with byte enables,
// error event pulses from logic on mclk and an asynchronous mode strap
`timescale 1ns/1ps

// Summary of operation
// - space visible only while in graphics port mode
// - identifier registers are 16-bit read-only constants
// - command bit 9 always reads zero
// - command bit 8 globally enables error messages
// - errors reported by hub message, no pin
// - message only for individually enabled error conditions
// - global enable clear blocks bridge error messages
// - error status recorded in bridge status register
// - command register resets to zero, mixed access
// - message mechanism enabled by either global enable
module agp_bridge_config_space #(
    // identity codes: arbitrary neutral values
    parameter logic [15:0] VENDOR_CODE = 16'h1a2b,
    parameter logic [15:0] DEVICE_CODE = 16'h3c4d,
    parameter logic [7:0] REVISION_CODE = 8'h01
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic agp_mode_pin,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [agp_cfg_pkg::CFG_AW-1:0] cfg_addr,
    input wire logic [agp_cfg_pkg::CFG_BW-1:0] cfg_be,
    input wire logic [agp_cfg_pkg::CFG_DW-1:0] cfg_wdata,
    input wire logic err_parity,
    input wire logic err_target_abort,
    input wire logic main_serr_en,
    input wire logic main_serr_req,
    input wire logic serr_msg_ready,
    output logic cfg_ack,
    output logic cfg_claim,
    output logic [agp_cfg_pkg::CFG_DW-1:0] cfg_rdata,
    output logic serr_msg_valid,
    output logic io_access_en,
    output logic mem_access_en,
    output logic bus_master_en
);
    import agp_cfg_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic mode_meta_reg;
    logic mode_sync_reg;
    logic serre_reg;
    logic [7:0] master_lat_reg;
    logic [7:0] secondary_bus_reg;
    logic [7:0] subord_bus_reg;
    logic [7:0] secondary_lat_reg;
    logic [7:0] io_base_reg;
    logic [7:0] io_limit_reg;
    logic [15:0] mem_base_reg;
    logic [15:0] mem_limit_reg;
    logic [15:0] pref_base_reg;
    logic [15:0] pref_limit_reg;
    logic [7:0] bridge_control_reg;
    logic [7:0] error_command_reg;
    logic [STS_NUM-1:0] sts_reg;
    logic [STS_NUM-1:0] sts_set;
    logic [STS_NUM-1:0] sts_clr;
    logic [15:0] cmd_value;
    logic [15:0] sts_value;
    logic [31:0] rd_word;
    logic access;
    logic dev1_err_hit;
    logic mech_en;
    logic msg_req;

    // a hidden function must not take writes, or a stale window could
    // come back to life when the port mode changes
    assign access = cfg_req && mode_sync_reg;

    function automatic logic lane_wr(input logic [7:0] off);
        lane_wr = access && cfg_we && (cfg_addr[7:2] == off[7:2])
            && cfg_be[off[1:0]];
    endfunction : lane_wr

    function automatic logic [7:0] wbyte(input logic [7:0] off);
        wbyte = cfg_wdata[8*off[1:0] +: 8];
    endfunction : wbyte

    // ------------------------------------------------------------------
    // mode strap synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_meta_reg <= 1'b0;
            mode_sync_reg <= 1'b0;
        end else if (ce) begin
            mode_meta_reg <= agp_mode_pin;
            mode_sync_reg <= mode_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // bridge command register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            io_access_en <= RST_BRIDGE_CMD[CMD_IO_EN_BIT];
            mem_access_en <= RST_BRIDGE_CMD[CMD_MEM_EN_BIT];
            bus_master_en <= RST_BRIDGE_CMD[CMD_BME_BIT];
            serre_reg <= RST_BRIDGE_CMD[CMD_SERRE_BIT];
        end else if (ce) begin
            if (lane_wr(OFF_BRIDGE_CMD)) begin
                io_access_en <= cfg_wdata[CMD_IO_EN_BIT];
                mem_access_en <= cfg_wdata[CMD_MEM_EN_BIT];
                bus_master_en <= cfg_wdata[CMD_BME_BIT];
            end
            if (lane_wr(OFF_BRIDGE_CMD + 8'h01)) begin
                serre_reg <= cfg_wdata[CMD_SERRE_BIT];
            end
        end
    end

    // only the writable bits are stored; the rest read as zero, fast
    // back-to-back included
    always_comb begin
        cmd_value = RST_BRIDGE_CMD;
        cmd_value[CMD_IO_EN_BIT] = io_access_en;
        cmd_value[CMD_MEM_EN_BIT] = mem_access_en;
        cmd_value[CMD_BME_BIT] = bus_master_en;
        cmd_value[CMD_SERRE_BIT] = serre_reg;
        cmd_value = cmd_value & CMD_WR_MASK;
    end

    // ------------------------------------------------------------------
    // plain read/write registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            master_lat_reg <= RST_BYTE_ZERO;
            secondary_bus_reg <= RST_BYTE_ZERO;
            subord_bus_reg <= RST_BYTE_ZERO;
            secondary_lat_reg <= RST_BYTE_ZERO;
            io_base_reg <= RST_IO_BASE;
            io_limit_reg <= RST_IO_LIMIT;
            bridge_control_reg <= RST_BYTE_ZERO;
            error_command_reg <= RST_BYTE_ZERO;
        end else if (ce) begin
            if (lane_wr(OFF_MASTER_LAT)) begin
                master_lat_reg <= wbyte(OFF_MASTER_LAT);
            end
            if (lane_wr(OFF_SECONDARY_BUS)) begin
                secondary_bus_reg <= wbyte(OFF_SECONDARY_BUS);
            end
            if (lane_wr(OFF_SUBORD_BUS)) begin
                subord_bus_reg <= wbyte(OFF_SUBORD_BUS);
            end
            if (lane_wr(OFF_SECONDARY_LAT)) begin
                secondary_lat_reg <= wbyte(OFF_SECONDARY_LAT);
            end
            if (lane_wr(OFF_IO_BASE)) begin
                io_base_reg <= wbyte(OFF_IO_BASE);
            end
            if (lane_wr(OFF_IO_LIMIT)) begin
                io_limit_reg <= wbyte(OFF_IO_LIMIT);
            end
            if (lane_wr(OFF_BRIDGE_CTRL)) begin
                bridge_control_reg <= wbyte(OFF_BRIDGE_CTRL);
            end
            if (lane_wr(OFF_ERROR_CMD)) begin
                error_command_reg <= wbyte(OFF_ERROR_CMD);
            end
        end
    end

    // ------------------------------------------------------------------
    // address windows, written a byte at a time
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mem_base_reg <= RST_WIN_BASE;
            mem_limit_reg <= RST_WIN_LIMIT;
            pref_base_reg <= RST_WIN_BASE;
            pref_limit_reg <= RST_WIN_LIMIT;
        end else if (ce) begin
            if (lane_wr(OFF_MEM_BASE)) begin
                mem_base_reg[7:0] <= wbyte(OFF_MEM_BASE);
            end
            if (lane_wr(OFF_MEM_BASE + 8'h01)) begin
                mem_base_reg[15:8] <= wbyte(OFF_MEM_BASE + 8'h01);
            end
            if (lane_wr(OFF_MEM_LIMIT)) begin
                mem_limit_reg[7:0] <= wbyte(OFF_MEM_LIMIT);
            end
            if (lane_wr(OFF_MEM_LIMIT + 8'h01)) begin
                mem_limit_reg[15:8] <= wbyte(OFF_MEM_LIMIT + 8'h01);
            end
            if (lane_wr(OFF_PREF_BASE)) begin
                pref_base_reg[7:0] <= wbyte(OFF_PREF_BASE);
            end
            if (lane_wr(OFF_PREF_BASE + 8'h01)) begin
                pref_base_reg[15:8] <= wbyte(OFF_PREF_BASE + 8'h01);
            end
            if (lane_wr(OFF_PREF_LIMIT)) begin
                pref_limit_reg[7:0] <= wbyte(OFF_PREF_LIMIT);
            end
            if (lane_wr(OFF_PREF_LIMIT + 8'h01)) begin
                pref_limit_reg[15:8] <= wbyte(OFF_PREF_LIMIT + 8'h01);
            end
        end
    end

    // ------------------------------------------------------------------
    // error gating and status
    // ------------------------------------------------------------------
    assign dev1_err_hit = serre_reg && (
        (err_parity && bridge_control_reg[CTRL_PARITY_SERR_BIT]) ||
        (err_target_abort && error_command_reg[ERRCMD_TA_SERR_BIT]));
    assign mech_en = serre_reg || main_serr_en;
    assign msg_req = dev1_err_hit || main_serr_req;

    assign sts_set[STS_TA] = err_target_abort;
    assign sts_set[STS_SERR] = dev1_err_hit;
    assign sts_set[STS_PERR] = err_parity;
    assign sts_clr[STS_TA] = lane_wr(OFF_BRIDGE_STS + 8'h01)
        && cfg_wdata[16 + STS_POS_TA];
    assign sts_clr[STS_SERR] = lane_wr(OFF_BRIDGE_STS + 8'h01)
        && cfg_wdata[16 + STS_POS_SERR];
    assign sts_clr[STS_PERR] = lane_wr(OFF_BRIDGE_STS + 8'h01)
        && cfg_wdata[16 + STS_POS_PERR];

    // write one to clear; an event in the clearing cycle still sticks
    for (genvar i = 0; i < STS_NUM; i++) begin : g_sts
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                sts_reg[i] <= 1'b0;
            end else if (ce) begin
                if (sts_set[i]) begin
                    sts_reg[i] <= 1'b1;
                end else if (sts_clr[i]) begin
                    sts_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        sts_value = RST_BRIDGE_STS;
        sts_value[STS_POS_TA] = sts_reg[STS_TA];
        sts_value[STS_POS_SERR] = sts_reg[STS_SERR];
        sts_value[STS_POS_PERR] = sts_reg[STS_PERR];
    end

    // there is no error pin: errors leave only as hub messages
    hub_serr_msg u_serr_msg (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .enable(mech_en),
        .req(msg_req),
        .ready(serr_msg_ready),
        .valid(serr_msg_valid)
    );

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = RD_RESERVED;
        case (cfg_addr[7:2])
            OFF_VENDOR_ID[7:2]: rd_word = {DEVICE_CODE, VENDOR_CODE};
            OFF_BRIDGE_CMD[7:2]: rd_word = {sts_value, cmd_value};
            OFF_REVISION[7:2]: rd_word = {RST_BASE_CLASS, RST_SUB_CLASS,
                RST_BYTE_ZERO, REVISION_CODE};
            OFF_MASTER_LAT[7:2]: rd_word = {RST_BYTE_ZERO, RST_HEADER_TYPE,
                master_lat_reg, RST_BYTE_ZERO};
            OFF_PRIMARY_BUS[7:2]: rd_word = {secondary_lat_reg,
                subord_bus_reg, secondary_bus_reg, RST_PRIMARY_BUS};
            OFF_IO_BASE[7:2]: rd_word = {RST_SECONDARY_STS, io_limit_reg,
                io_base_reg};
            OFF_MEM_BASE[7:2]: rd_word = {mem_limit_reg, mem_base_reg};
            OFF_PREF_BASE[7:2]: rd_word = {pref_limit_reg, pref_base_reg};
            OFF_BRIDGE_CTRL[7:2]: rd_word = {RST_BYTE_ZERO,
                bridge_control_reg, RST_BYTE_ZERO, RST_BYTE_ZERO};
            OFF_ERROR_CMD[7:2]: rd_word = {RST_BYTE_ZERO, RST_BYTE_ZERO,
                RST_BYTE_ZERO, error_command_reg};
            default: rd_word = RD_RESERVED;
        endcase
    end

    // every request is answered one cycle later; a hidden function
    // answers unclaimed with all ones, as an empty slot would
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ack <= 1'b0;
            cfg_claim <= 1'b0;
            cfg_rdata <= RD_RESERVED;
        end else if (ce) begin
            cfg_ack <= cfg_req;
            cfg_claim <= access;
            if (cfg_req) begin
                cfg_rdata <= mode_sync_reg ? rd_word : RD_HIDDEN;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_hidden;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req && ce && !mode_sync_reg |=>
            cfg_ack && !cfg_claim && (cfg_rdata == RD_HIDDEN);
    endproperty
    a_hidden: assert property (p_hidden)
        else $error("hidden function answered a request");

    property p_ident;
        @(posedge mclk) disable iff (!rst_b)
        access && ce && (cfg_addr[7:2] == OFF_VENDOR_ID[7:2]) |=>
            cfg_claim && (cfg_rdata == {DEVICE_CODE, VENDOR_CODE});
    endproperty
    a_ident: assert property (p_ident)
        else $error("identifier read returned a wrong value");

    property p_fast_btb_zero;
        @(posedge mclk) disable iff (!rst_b)
        access && ce && (cfg_addr[7:2] == OFF_BRIDGE_CMD[7:2]) |=>
            !cfg_rdata[CMD_FAST_BTB_BIT];
    endproperty
    a_fast_btb_zero: assert property (p_fast_btb_zero)
        else $error("fast back-to-back bit read as one");

    property p_serre_write;
        @(posedge mclk) disable iff (!rst_b)
        ce && lane_wr(OFF_BRIDGE_CMD + 8'h01) |=>
            serre_reg == $past(cfg_wdata[CMD_SERRE_BIT]);
    endproperty
    a_serre_write: assert property (p_serre_write)
        else $error("global error enable did not take the write");

    property p_msg_sent;
        @(posedge mclk) disable iff (!rst_b)
        ce && serre_reg && err_target_abort
            && error_command_reg[ERRCMD_TA_SERR_BIT] |=> serr_msg_valid;
    endproperty
    a_msg_sent: assert property (p_msg_sent)
        else $error("enabled error raised no hub message");

    property p_no_msg;
        @(posedge mclk) disable iff (!rst_b)
        !serre_reg && !main_serr_en && !serr_msg_valid |=> !serr_msg_valid;
    endproperty
    a_no_msg: assert property (p_no_msg)
        else $error("message sent with both global enables clear");

    property p_status;
        @(posedge mclk) disable iff (!rst_b)
        ce && dev1_err_hit |=> sts_reg[STS_SERR] ##1 1'b1;
    endproperty
    a_status: assert property (p_status)
        else $error("signaled system error status not recorded");

    property p_cmd_reset;
        @(posedge mclk) $rose(rst_b) |-> (cmd_value == RST_BRIDGE_CMD);
    endproperty
    a_cmd_reset: assert property (p_cmd_reset)
        else $error("command register not zero after reset");

    property p_mech_or;
        @(posedge mclk) disable iff (!rst_b)
        ce && main_serr_req && main_serr_en && !serre_reg |=>
            serr_msg_valid;
    endproperty
    a_mech_or: assert property (p_mech_or)
        else $error("main function enable did not open the mechanism");

    c_hidden_read: cover property (@(posedge mclk) disable iff (!rst_b)
        cfg_req && !mode_sync_reg);
    c_msg_taken: cover property (@(posedge mclk) disable iff (!rst_b)
        serr_msg_valid && serr_msg_ready);
    c_set_and_clear: cover property (@(posedge mclk) disable iff (!rst_b)
        sts_set[STS_SERR] && sts_clr[STS_SERR]);

endmodule : agp_bridge_config_space

// ---- dv/hub_model.sv ----
// hub side model: takes system-error messages after a chosen delay
// assumes valid holds until it is seen with ready on a rising edge
`timescale 1ns/1ps
module hub_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic valid,
    input wire logic [3:0] delay,
    output logic ready
);
    logic [3:0] wait_reg;
    // ready pulses once per message, so a slow hub keeps it pending
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg <= 4'h0;
            ready <= 1'b0;
        end else if (valid && !ready && wait_reg >= delay) begin
            ready <= 1'b1;
            wait_reg <= 4'h0;
        end else begin
            ready <= 1'b0;
            wait_reg <= valid ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule : hub_model

// ---- dv/tb.sv ----
// self-checking bench for the bridge configuration bank
// assumes the design package and the hub model are compiled first
`timescale 1ns/1ps
module tb;
    import agp_cfg_pkg::*;
    // identity values are arbitrary
    localparam logic [15:0] VEN = 16'h5a5a;
    localparam logic [15:0] DEV = 16'h6b6b;
    localparam logic [7:0] REV = 8'h07;
    logic mclk = 1'b0, rst_b = 1'b0, mode = 1'b0, req = 1'b0, we = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] be = 4'h0, dly = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic perr = 1'b0, tabt = 1'b0, men = 1'b0, mreq = 1'b0, ce = 1'b1;
    logic ack, claim, valid, ready, io_en, mem_en, bm_en, gate, send;
    logic [15:0] cmd;
    logic [7:0] bc, ec;
    int fails = 0, checks_done = 0;
    logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c,
        8'h20, 8'h24, 8'h3c, 8'h40, 8'h80};
    logic [31:0] re [11] = '{{DEV, VEN}, 32'h0020_0000,
        {8'h06, 8'h04, 8'h00, REV}, 32'h0001_0000, 32'h0, 32'h02a0_00f0,
        32'h0000_fff0, 32'h0000_fff0, 32'h0, 32'h0, 32'h0};
    always #2.5 mclk = ~mclk;
    agp_bridge_config_space #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV),
        .REVISION_CODE(REV)) i_agp_bridge_config_space (
        .mclk(mclk), .rst_b(rst_b), .ce(ce), .agp_mode_pin(mode),
        .cfg_req(req), .cfg_we(we), .cfg_addr(addr), .cfg_be(be),
        .cfg_wdata(wdata), .err_parity(perr), .err_target_abort(tabt),
        .main_serr_en(men), .main_serr_req(mreq), .serr_msg_ready(ready),
        .cfg_ack(ack), .cfg_claim(claim), .cfg_rdata(rdata),
        .serr_msg_valid(valid), .io_access_en(io_en),
        .mem_access_en(mem_en), .bus_master_en(bm_en));
    hub_model i_hub_model (.mclk(mclk), .rst_b(rst_b), .valid(valid),
        .delay(dly), .ready(ready));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cfg(input logic w, input logic [7:0] a,
                       input logic [3:0] b, input logic [31:0] d,
                       input logic cl);
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        addr <= a;
        be <= b;
        wdata <= d;
        @(posedge mclk);
        req <= 1'b0;
        #1;
        chk("cfg_ack", 32'h1, {31'h0, ack});
        chk("cfg_claim", {31'h0, cl}, {31'h0, claim});
        rd = rdata;
    endtask : cfg
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    initial begin
        logic [31:0] r;
        r = $urandom(32'h2823);
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        cfg(1'b0, 8'h00, 4'h0, 32'h0, 1'b0);
        chk("hidden read", RD_HIDDEN, rd);
        // a hidden write must leave the bus numbers at their reset values
        cfg(1'b1, 8'h18, 4'hf, 32'hffff_ffff, 1'b0);
        mode <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 11; i++) begin
            cfg(1'b0, ra[i], 4'h0, 32'h0, 1'b1);
            chk("reset value", re[i], rd);
        end
        cfg(1'b1, 8'h00, 4'hf, 32'hffff_ffff, 1'b1);
        cfg(1'b0, 8'h00, 4'h0, 32'h0, 1'b1);
        chk("identifiers", {DEV, VEN}, rd);
        cfg(1'b1, 8'h04, 4'h3, 32'h0000_ffff, 1'b1);
        cfg(1'b0, 8'h04, 4'h0, 32'h0, 1'b1);
        chk("command", 32'h0020_0107, rd);
        chk("enables", 32'h7, {29'h0, bm_en, mem_en, io_en});
        r = $urandom;
        cfg(1'b1, 8'h18, 4'hf, r, 1'b1);
        cfg(1'b0, 8'h18, 4'h0, 32'h0, 1'b1);
        chk("bus numbers", {r[31:8], 8'h00}, rd);
        // fixed cases first: all enabled, then the main enable alone
        for (int i = 0; i < 24; i++) begin
            r = (i == 0) ? 32'h0000_070f :
                (i == 1) ? 32'h0000_0408 : $urandom;
            cmd = {7'h0, r[0], 8'h0};
            bc = {5'h0, r[1], 2'h0};
            ec = {7'h0, r[2]};
            men <= r[3];
            dly <= r[7:4];
            cfg(1'b1, 8'h04, 4'h3, {16'h0, cmd}, 1'b1);
            cfg(1'b1, 8'h3c, 4'h4, {8'h0, bc, 16'h0}, 1'b1);
            cfg(1'b1, 8'h40, 4'h1, {24'h0, ec}, 1'b1);
            perr <= r[8];
            tabt <= r[9];
            mreq <= r[10];
            @(posedge mclk);
            perr <= 1'b0;
            tabt <= 1'b0;
            mreq <= 1'b0;
            #1;
            gate = cmd[8] & ((r[8] & bc[2]) | (r[9] & ec[0]));
            send = (gate | r[10]) & (cmd[8] | r[3]);
            chk("serr_msg_valid", {31'h0, send}, {31'h0, valid});
            for (int k = 0; k < 40 && valid === 1'b1; k++) begin
                @(posedge mclk);
                #1;
            end
            chk("message taken", 32'h0, {31'h0, valid});
            cfg(1'b0, 8'h04, 4'h0, 32'h0, 1'b1);
            chk("status", {r[8], gate, 1'b0, r[9], 12'h020, cmd}, rd);
            cfg(1'b1, 8'h04, 4'h8, 32'hd000_0000, 1'b1);
        end
        // a frozen block must miss an error pulse entirely
        ce <= 1'b0;
        tabt <= 1'b1;
        @(posedge mclk);
        tabt <= 1'b0;
        repeat (2) @(posedge mclk);
        ce <= 1'b1;
        #1;
        chk("frozen message", 32'h0, {31'h0, valid});
        cfg(1'b0, 8'h04, 4'h0, 32'h0, 1'b1);
        chk("frozen status", {16'h0020, cmd}, rd);
        report_and_stop();
    end
endmodule : tb
